// ==== hw/ucd_cfg.svh ====
`ifndef UCD_CFG_SVH
`define UCD_CFG_SVH
// Command groups by upper nibble
`define UCD_GRP_BUFWR 4'h0
`define UCD_GRP_BUFRD 4'h1
`define UCD_GRP_CFGWR 4'h2
`define UCD_GRP_CFGRD 4'h3
`define UCD_GRP_STALL 4'h4
`define UCD_GRP_STAT 4'h5
`define UCD_GRP_VALID 4'h6
`define UCD_GRP_CLEAR 4'h7
`define UCD_GRP_UNSTL 4'h8
`define UCD_GRP_ERR 4'ha
`define UCD_GRP_COPY 4'hd
// Illegal codes inside groups
`define UCD_ILL_BUFWR 8'h00
`define UCD_ILL_BUFRD 8'h11
`define UCD_ILL_VALID 8'h60
`define UCD_ILL_CLEAR 8'h71
// Single register codes
`define UCD_UNLOCK 8'hb0
`define UCD_SCR_WR 8'hb2
`define UCD_SCR_RD 8'hb3
`define UCD_FRAME_RD 8'hb4
`define UCD_ID_RD 8'hb5
`define UCD_ADDR_WR 8'hb6
`define UCD_ADDR_RD 8'hb7
`define UCD_MODE_WR 8'hb8
`define UCD_MODE_RD 8'hb9
`define UCD_HW_WR 8'hba
`define UCD_HW_RD 8'hbb
`define UCD_IRQ_RD 8'hc0
`define UCD_IRQEN_WR 8'hc2
`define UCD_IRQEN_RD 8'hc3
`define UCD_DMAC_WR 8'hf0
`define UCD_DMAC_RD 8'hf1
`define UCD_DMAN_WR 8'hf2
`define UCD_DMAN_RD 8'hf3
`define UCD_SETUP 8'hf4
`define UCD_RESET 8'hf6
// Field positions and reset values
`define UCD_CFG_EN_BIT 7
`define UCD_CFG_ISO_BIT 4
`define UCD_MODE_RST 8'h80
// Packet byte limits
`define UCD_ISO_MAX 11'h3ff
`define UCD_STD_MAX 11'h040
`endif

// ==== hw/ucd_decoder.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ucd_cfg.svh"
module ucd_decoder #(
   parameter logic [15:0] PART_ID = 16'h5a5a // Arbitrary identity value
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire ucd_pkg::ucd_acc_s acc_i,
   input wire ucd_pkg::ucd_dev_s dev_i,
   input wire logic [15:0] buf_rdata_i,
   input wire logic usb_rst_i,
   input wire logic lock_i,
   output logic [15:0] rdata_o,
   output logic rvalid_o,
   output ucd_pkg::ucd_act_s act_o,
   output logic buf_wr_o,
   output logic buf_pop_o,
   output logic [3:0] buf_ep_o,
   output logic [15:0] buf_wdata_o,
   output logic [15:0][7:0] ep_cfg_o,
   output logic [7:0] bus_address_reg_o,
   output logic [7:0] operating_mode_reg_o,
   output logic [15:0] hardware_setup_reg_o,
   output logic [31:0] irq_mask_reg_o,
   output logic [15:0] transfer_engine_setup_reg_o,
   output logic [15:0] transfer_engine_count_reg_o
);
   import ucd_pkg::*;
   ucd_state_s s_r; // Registered state
   ucd_state_s s_nxt; // Next state
   ucd_kind_e kind_w; // Kind of incoming code
   ucd_kind_e cur_w; // Kind of held command
   logic [10:0] lim_w; // Word limit of held command
   logic [3:0] ep_w; // Endpoint of held command
   // Reset image of the whole state
   function automatic ucd_state_s rst_state();
      ucd_state_s r;
      r = '0;
      r.phase = UCD_IDLE;
      r.mode = `UCD_MODE_RST;
      r.unlocked = 1'b1;
      return r;
   endfunction : rst_state
   // Classify a command code
   function automatic ucd_kind_e kind_of(input logic [7:0] c);
      ucd_kind_e k;
      k = UCD_K_NONE;
      case (c[7:4])
         `UCD_GRP_BUFWR: k = (c == `UCD_ILL_BUFWR) ? UCD_K_NONE : UCD_K_BUFWR;
         `UCD_GRP_BUFRD: k = (c == `UCD_ILL_BUFRD) ? UCD_K_NONE : UCD_K_BUFRD;
         `UCD_GRP_CFGWR: k = UCD_K_CFGWR;
         `UCD_GRP_CFGRD: k = UCD_K_CFGRD;
         `UCD_GRP_STALL: k = UCD_K_STALL;
         `UCD_GRP_STAT: k = UCD_K_STAT;
         `UCD_GRP_VALID: k = (c == `UCD_ILL_VALID) ? UCD_K_NONE : UCD_K_VALID;
         `UCD_GRP_CLEAR: k = (c == `UCD_ILL_CLEAR) ? UCD_K_NONE : UCD_K_CLEAR;
         `UCD_GRP_UNSTL: k = UCD_K_UNSTL;
         `UCD_GRP_ERR: k = UCD_K_ERR;
         `UCD_GRP_COPY: k = UCD_K_COPY;
         default: begin
            case (c)
               `UCD_ADDR_WR, `UCD_MODE_WR, `UCD_HW_WR, `UCD_IRQEN_WR,
               `UCD_DMAC_WR, `UCD_DMAN_WR, `UCD_UNLOCK, `UCD_SCR_WR: k = UCD_K_REGWR;
               `UCD_ADDR_RD, `UCD_MODE_RD, `UCD_HW_RD, `UCD_IRQEN_RD, `UCD_DMAC_RD,
               `UCD_DMAN_RD, `UCD_SCR_RD, `UCD_FRAME_RD, `UCD_ID_RD, `UCD_IRQ_RD: k = UCD_K_REGRD;
               `UCD_SETUP: k = UCD_K_SETUP;
               `UCD_RESET: k = UCD_K_RESET;
               default: k = UCD_K_NONE;
            endcase
         end
      endcase
      return k;
   endfunction : kind_of
   // Words in a packet of at most n bytes plus its length word
   function automatic logic [10:0] pkt_words(input logic [10:0] n);
      return ((n + 11'h001) >> 1) + 11'h001;
   endfunction : pkt_words
   // Word limit for the held command
   always_comb begin
      kind_w = kind_of(acc_i.data[7:0]);
      cur_w = kind_of(s_r.cmd);
      ep_w = s_r.cmd[3:0];
      case (cur_w)
         UCD_K_BUFWR, UCD_K_BUFRD: begin
            lim_w = s_r.cfg[ep_w][`UCD_CFG_ISO_BIT] ? pkt_words(`UCD_ISO_MAX)
                                                    : pkt_words(`UCD_STD_MAX);
         end
         UCD_K_REGWR, UCD_K_REGRD: begin
            // Four-byte registers take two words
            lim_w = (s_r.cmd == `UCD_IRQEN_WR || s_r.cmd == `UCD_IRQEN_RD ||
                     s_r.cmd == `UCD_IRQ_RD) ? 11'h002 : 11'h001;
         end
         default: lim_w = 11'h001;
      endcase
   end
   // Command and data phase sequencing
   always_comb begin
      s_nxt = s_r;
      s_nxt.act = '0;
      s_nxt.rvalid = 1'b0;
      s_nxt.buf_wr = 1'b0;
      s_nxt.buf_pop = 1'b0;
      if (lock_i) begin
         s_nxt.unlocked = 1'b0;
      end
      if (acc_i.wr && acc_i.a0) begin
         // Command phase, upper byte ignored
         s_nxt.cmd = acc_i.data[7:0];
         s_nxt.idx = '0;
         s_nxt.phase = UCD_DATA;
         case (kind_w)
            UCD_K_STALL: begin
               s_nxt.act.stall[acc_i.data[3:0]] = 1'b1;
               s_nxt.phase = UCD_IDLE;
            end
            UCD_K_UNSTL: begin
               s_nxt.act.unstall[acc_i.data[3:0]] = 1'b1;
               s_nxt.phase = UCD_IDLE;
            end
            UCD_K_VALID: begin
               s_nxt.act.validate[acc_i.data[3:0]] = 1'b1;
               s_nxt.phase = UCD_IDLE;
            end
            UCD_K_CLEAR: begin
               s_nxt.act.clear[acc_i.data[3:0]] = 1'b1;
               s_nxt.phase = UCD_IDLE;
            end
            UCD_K_SETUP: begin
               s_nxt.act.setup_ack = 1'b1;
               s_nxt.phase = UCD_IDLE;
            end
            UCD_K_RESET: begin
               s_nxt = rst_state();
            end
            UCD_K_NONE: begin
               s_nxt.phase = UCD_IDLE;
            end
            default: begin
               s_nxt.phase = UCD_DATA;
            end
         endcase
      end else if (acc_i.wr && !acc_i.a0 && s_r.phase == UCD_DATA) begin
         // Data phase write, one word per access
         s_nxt.idx = s_r.idx + 11'h001;
         if (s_r.idx + 11'h001 == lim_w) begin
            s_nxt.phase = UCD_FULL;
         end
         case (cur_w)
            UCD_K_CFGWR: begin
               if (s_r.unlocked) begin
                  s_nxt.cfg[ep_w] = acc_i.data[7:0];
               end
            end
            UCD_K_BUFWR: begin
               s_nxt.buf_wr = 1'b1;
               s_nxt.buf_ep = ep_w;
               s_nxt.buf_wdata = acc_i.data;
            end
            UCD_K_REGWR: begin
               if (s_r.cmd == `UCD_UNLOCK) begin
                  s_nxt.unlocked = 1'b1;
               end else if (s_r.unlocked) begin
                  case (s_r.cmd)
                     `UCD_ADDR_WR: s_nxt.addr = acc_i.data[7:0];
                     `UCD_MODE_WR: s_nxt.mode = acc_i.data[7:0];
                     `UCD_HW_WR: s_nxt.hwcfg = acc_i.data;
                     `UCD_IRQEN_WR: begin
                        if (s_r.idx == 11'h000) begin
                           s_nxt.irqen[15:0] = acc_i.data;
                        end else begin
                           s_nxt.irqen[31:16] = acc_i.data;
                        end
                     end
                     `UCD_DMAC_WR: s_nxt.dmacfg = acc_i.data;
                     `UCD_DMAN_WR: s_nxt.dmacnt = acc_i.data;
                     `UCD_SCR_WR: s_nxt.scratch = acc_i.data;
                     default: s_nxt.scratch = s_r.scratch;
                  endcase
               end
            end
            default: begin
               // Write to a read command is dropped
               s_nxt.phase = s_r.phase;
               s_nxt.idx = s_r.idx;
            end
         endcase
      end else if (acc_i.rd && !acc_i.a0) begin
         // Data phase read; answer one cycle later
         s_nxt.rvalid = 1'b1;
         s_nxt.rdata = '0;
         if (s_r.phase == UCD_DATA) begin
            s_nxt.idx = s_r.idx + 11'h001;
            if (s_r.idx + 11'h001 == lim_w) begin
               s_nxt.phase = UCD_FULL;
            end
            case (cur_w)
               UCD_K_CFGRD: s_nxt.rdata = {8'h00, s_r.cfg[ep_w]};
               UCD_K_STAT: begin
                  s_nxt.rdata = {8'h00, dev_i.status[ep_w]};
                  s_nxt.act.stat_clr[ep_w] = 1'b1;
               end
               UCD_K_COPY: s_nxt.rdata = {8'h00, dev_i.status[ep_w]};
               UCD_K_ERR: s_nxt.rdata = {8'h00, dev_i.fault[ep_w]};
               UCD_K_BUFRD: begin
                  s_nxt.rdata = buf_rdata_i;
                  s_nxt.buf_pop = 1'b1;
                  s_nxt.buf_ep = ep_w;
               end
               UCD_K_REGRD: begin
                  case (s_r.cmd)
                     `UCD_ADDR_RD: s_nxt.rdata = {8'h00, s_r.addr};
                     `UCD_MODE_RD: s_nxt.rdata = {8'h00, s_r.mode};
                     `UCD_HW_RD: s_nxt.rdata = s_r.hwcfg;
                     `UCD_IRQEN_RD: begin
                        s_nxt.rdata = (s_r.idx == 11'h000) ? s_r.irqen[15:0]
                                                           : s_r.irqen[31:16];
                     end
                     `UCD_DMAC_RD: s_nxt.rdata = s_r.dmacfg;
                     `UCD_DMAN_RD: s_nxt.rdata = s_r.dmacnt;
                     `UCD_SCR_RD: s_nxt.rdata = s_r.scratch;
                     `UCD_FRAME_RD: s_nxt.rdata = dev_i.frame;
                     `UCD_ID_RD: s_nxt.rdata = PART_ID;
                     `UCD_IRQ_RD: begin
                        s_nxt.rdata = (s_r.idx == 11'h000) ? dev_i.cause[15:0]
                                                           : dev_i.cause[31:16];
                     end
                     default: s_nxt.rdata = '0;
                  endcase
               end
               default: begin
                  // Read on a write command returns zero, no progress
                  s_nxt.phase = s_r.phase;
                  s_nxt.idx = s_r.idx;
               end
            endcase
         end
      end
      // Bus reset wins over a setup write in the same cycle
      if (usb_rst_i) begin
         for (int i = 0; i < 16; i++) begin
            s_nxt.cfg[i][`UCD_CFG_EN_BIT] = 1'b0;
         end
      end
   end
   // State register
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s_r <= rst_state();
      end else begin
         s_r <= s_nxt;
      end
   end
   // Outputs straight from the state register
   assign rdata_o = s_r.rdata;
   assign rvalid_o = s_r.rvalid;
   assign act_o = s_r.act;
   assign buf_wr_o = s_r.buf_wr;
   assign buf_pop_o = s_r.buf_pop;
   assign buf_ep_o = s_r.buf_ep;
   assign buf_wdata_o = s_r.buf_wdata;
   assign ep_cfg_o = s_r.cfg;
   assign bus_address_reg_o = s_r.addr;
   assign operating_mode_reg_o = s_r.mode;
   assign hardware_setup_reg_o = s_r.hwcfg;
   assign irq_mask_reg_o = s_r.irqen;
   assign transfer_engine_setup_reg_o = s_r.dmacfg;
   assign transfer_engine_count_reg_o = s_r.dmacnt;
   // Command write with a given upper nibble
   sequence cmd_grp(logic [3:0] g);
      acc_i.wr && acc_i.a0 && acc_i.data[7:4] == g;
   endsequence
   // Data read while a command is open
   sequence data_rd;
      acc_i.rd && !acc_i.a0 && s_r.phase == UCD_DATA;
   endsequence
   AST_STALL: assert property (@(posedge clk_i) disable iff (!nrst_i)
      cmd_grp(`UCD_GRP_STALL) |=> act_o.stall == (16'h0001 << $past(acc_i.data[3:0])))
      else $error("stall pulse missing");
   AST_UNSTALL: assert property (@(posedge clk_i) disable iff (!nrst_i)
      cmd_grp(`UCD_GRP_UNSTL) |=> act_o.unstall == (16'h0001 << $past(acc_i.data[3:0]))
      ##1 (act_o.unstall == 16'h0000
      || $past(acc_i.wr && acc_i.a0 && acc_i.data[7:4] == `UCD_GRP_UNSTL)))
      else $error("unstall pulse wrong");
   AST_VALID: assert property (@(posedge clk_i) disable iff (!nrst_i)
      cmd_grp(`UCD_GRP_VALID) |=> act_o.validate == (($past(acc_i.data[7:0]) == `UCD_ILL_VALID)
      ? 16'h0000 : (16'h0001 << $past(acc_i.data[3:0]))))
      else $error("validate pulse wrong");
   AST_CLEAR: assert property (@(posedge clk_i) disable iff (!nrst_i)
      cmd_grp(`UCD_GRP_CLEAR) ##0 (acc_i.data[7:0] != `UCD_ILL_CLEAR)
      |=> act_o.clear[$past(acc_i.data[3:0])])
      else $error("clear pulse missing");
   AST_SETUP: assert property (@(posedge clk_i) disable iff (!nrst_i)
      act_o.setup_ack |-> $past(acc_i.wr && acc_i.a0 && acc_i.data[7:0] == `UCD_SETUP))
      else $error("setup ack without command");
   AST_BUSRST: assert property (@(posedge clk_i) disable iff (!nrst_i)
      usb_rst_i |=> (ep_cfg_o[0][`UCD_CFG_EN_BIT] == 1'b0 && ep_cfg_o[15][`UCD_CFG_EN_BIT] == 1'b0))
      else $error("endpoint still enabled after bus reset");
   AST_COPY: assert property (@(posedge clk_i) disable iff (!nrst_i)
      data_rd ##0 (kind_of(s_r.cmd) == UCD_K_COPY) |=> rvalid_o && act_o.stat_clr == 16'h0000)
      else $error("status copy cleared status");
   AST_STAT: assert property (@(posedge clk_i) disable iff (!nrst_i)
      data_rd ##0 (kind_of(s_r.cmd) == UCD_K_STAT) |=> rvalid_o && rdata_o[15:8] == 8'h00
      && act_o.stat_clr != 16'h0000)
      else $error("status read wrong");
   AST_RESET: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (acc_i.wr && acc_i.a0 && acc_i.data[7:0] == `UCD_RESET && !usb_rst_i)
      |=> operating_mode_reg_o == `UCD_MODE_RST && irq_mask_reg_o == 32'h0)
      else $error("device reset incomplete");
endmodule : ucd_decoder
`default_nettype wire

// ==== hw/ucd_pkg.sv ====
package ucd_pkg;
   // Data phase progress
   typedef enum logic [1:0] {UCD_IDLE = 2'b00, UCD_DATA = 2'b01, UCD_FULL = 2'b11} ucd_phase_e;
   // Decoded command kind
   typedef enum logic [3:0] {
      UCD_K_NONE, UCD_K_BUFWR, UCD_K_BUFRD, UCD_K_CFGWR, UCD_K_CFGRD, UCD_K_STALL,
      UCD_K_UNSTL, UCD_K_STAT, UCD_K_COPY, UCD_K_VALID, UCD_K_CLEAR, UCD_K_SETUP,
      UCD_K_ERR, UCD_K_REGWR, UCD_K_REGRD, UCD_K_RESET
   } ucd_kind_e;
   // One bus access from the processor side
   typedef struct packed {
      logic wr;
      logic rd;
      logic a0;
      logic [15:0] data;
   } ucd_acc_s;
   // State supplied by the endpoint engine
   typedef struct packed {
      logic [15:0][7:0] status;
      logic [15:0][7:0] fault;
      logic [15:0] frame;
      logic [31:0] cause;
   } ucd_dev_s;
   // Endpoint action pulses
   typedef struct packed {
      logic [15:0] stall;
      logic [15:0] unstall;
      logic [15:0] validate;
      logic [15:0] clear;
      logic [15:0] stat_clr;
      logic setup_ack;
   } ucd_act_s;
   // Complete decoder state
   typedef struct packed {
      ucd_phase_e phase;
      logic [7:0] cmd;
      logic [10:0] idx;
      logic [15:0][7:0] cfg;
      logic [7:0] addr;
      logic [7:0] mode;
      logic [15:0] hwcfg;
      logic [31:0] irqen;
      logic [15:0] dmacfg;
      logic [15:0] dmacnt;
      logic [15:0] scratch;
      logic unlocked;
      ucd_act_s act;
      logic [15:0] rdata;
      logic rvalid;
      logic buf_wr;
      logic buf_pop;
      logic [3:0] buf_ep;
      logic [15:0] buf_wdata;
   } ucd_state_s;
endpackage : ucd_pkg

// ==== tb/tb_usb_device_command_decoder.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_usb_device_command_decoder;
   import ucd_pkg::*;
   logic clk_i = 1'b0; // 200 MHz clock
   logic nrst_i = 1'b0; // Active low reset
   ucd_acc_s acc = '0; // Processor access
   ucd_dev_s dev; // Engine levels
   logic [15:0] buf_rdata; // Engine head word
   logic usb_rst = 1'b0; // Bus reset
   logic lock = 1'b0; // Lock pulse
   logic [15:0] rdata; // Read answer
   logic rvalid; // Read strobe
   ucd_act_s act; // Action pulses
   logic buf_wr, buf_pop; // Buffer strobes
   logic [3:0] buf_ep; // Buffer endpoint
   logic [15:0] buf_wdata; // Buffer word
   logic [15:0][7:0] ep_cfg; // Endpoint setup bytes
   logic [7:0] addr, mode; // Byte registers
   logic [15:0] hw, dmac, dman; // Word registers
   logic [31:0] irqm; // Interrupt mask
   int n_mismatch = 0; // Failed checks
   int tests_run = 0; // All checks
   int cyc = 0; // Cycle count for timeout
   logic [7:0] npop = 8'h00; // Expected head word count
   // Clock
   always #2.5 clk_i = ~clk_i;
   // Arbitrary identity value
   ucd_decoder #(.PART_ID(16'h3c3c)) ucd_decoder_inst (
      .clk_i(clk_i), .nrst_i(nrst_i), .acc_i(acc), .dev_i(dev), .buf_rdata_i(buf_rdata),
      .usb_rst_i(usb_rst), .lock_i(lock), .rdata_o(rdata), .rvalid_o(rvalid), .act_o(act),
      .buf_wr_o(buf_wr), .buf_pop_o(buf_pop), .buf_ep_o(buf_ep), .buf_wdata_o(buf_wdata),
      .ep_cfg_o(ep_cfg), .bus_address_reg_o(addr), .operating_mode_reg_o(mode),
      .hardware_setup_reg_o(hw), .irq_mask_reg_o(irqm),
      .transfer_engine_setup_reg_o(dmac), .transfer_engine_count_reg_o(dman));
   // Endpoint engine on the far side
   ucd_engine_model ucd_engine_model_inst (
      .clk_i(clk_i), .nrst_i(nrst_i), .buf_pop_i(buf_pop), .dev_o(dev),
      .buf_rdata_o(buf_rdata));
   // Verdict and end of run
   task test_done;
      begin
         $display("checks %0d mismatches %0d", tests_run, n_mismatch);
         if (n_mismatch == 0 && tests_run > 0) begin
            $display("STATUS OK");
         end else begin
            $display("STATUS NOT OK");
         end
         $finish;
      end
   endtask : test_done
   // Hang guard
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         $display("unexpected at %0t: timeout", $time);
         test_done();
      end
   end
   // Compare and count
   task chk(input logic [127:0] got, input logic [127:0] exp, input string m);
      begin
         tests_run++;
         if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
         end
      end
   endtask : chk
   // One access, held for one sampling edge; results settle by return
   task xfer(input logic w, input logic r, input logic a, input logic [15:0] d);
      begin
         @(negedge clk_i);
         acc = '{wr: w, rd: r, a0: a, data: d};
         @(negedge clk_i);
         acc = '0;
      end
   endtask : xfer
   // Command with junk upper byte
   task cmd(input logic [7:0] c);
      xfer(1'b1, 1'b0, 1'b1, {8'he7, c});
   endtask : cmd
   // Data word write
   task wd(input logic [15:0] d);
      xfer(1'b1, 1'b0, 1'b0, d);
   endtask : wd
   // Data word read
   task rd(output logic [15:0] v);
      begin
         xfer(1'b0, 1'b1, 1'b0, 16'h0000);
         chk(rvalid, 1'b1, "read strobe");
         v = rdata;
      end
   endtask : rd
   // Register image after power-on or device reset
   task chk_idle;
      begin
         chk(ep_cfg, '0, "setup bytes");
         chk({addr, mode, hw, irqm, dmac, dman}, {8'h00, 8'h80, 80'h0}, "registers");
         chk(act, '0, "actions");
      end
   endtask : chk_idle
   // Write then read back a register, low word first
   task reg_rw(input logic [7:0] c, input logic [31:0] v, input logic two, input logic b);
      logic [15:0] r;
      begin
         cmd(c);
         wd(b ? {8'hee, v[7:0]} : v[15:0]);
         if (two) begin
            wd(v[31:16]);
         end
         cmd(c + 8'h01);
         rd(r);
         chk(r, v[15:0], "register low");
         if (two) begin
            rd(r);
            chk(r, v[31:16], "register high");
         end
      end
   endtask : reg_rw
   // Setup bytes written, read back, then bus reset
   task t_cfg;
      logic [15:0] r;
      begin
         for (int i = 0; i < 16; i++) begin
            cmd(8'h20 + 8'(i));
            wd({8'hff, 8'h80 | 8'(i)});
            chk(ep_cfg[i], 8'h80 | 8'(i), "setup write");
         end
         for (int i = 0; i < 16; i++) begin
            cmd(8'h30 + 8'(i));
            rd(r);
            chk(r, {8'h00, 8'h80 | 8'(i)}, "setup read");
         end
         @(negedge clk_i);
         usb_rst = 1'b1;
         @(negedge clk_i);
         usb_rst = 1'b0;
         @(negedge clk_i);
         for (int i = 0; i < 16; i++) begin
            chk(ep_cfg[i], 8'(i), "bus reset");
         end
         $display("test setup done");
      end
   endtask : t_cfg
   // Register table
   task t_regs;
      begin
         reg_rw(8'hb6, 32'h5a, 1'b0, 1'b1);
         chk(addr, 8'h5a, "address");
         reg_rw(8'hb8, 32'h15, 1'b0, 1'b1);
         chk(mode, 8'h15, "mode");
         reg_rw(8'hba, 32'h3cc3, 1'b0, 1'b0);
         chk(hw, 16'h3cc3, "hardware");
         reg_rw(8'hc2, 32'h1357_9bdf, 1'b1, 1'b0);
         chk(irqm, 32'h1357_9bdf, "mask");
         reg_rw(8'hf0, 32'h0f1e, 1'b0, 1'b0);
         chk(dmac, 16'h0f1e, "engine setup");
         reg_rw(8'hf2, 32'he1f0, 1'b0, 1'b0);
         chk(dman, 16'he1f0, "engine count");
         reg_rw(8'hb2, 32'h6996, 1'b0, 1'b0);
         $display("test registers done");
      end
   endtask : t_regs
   // Pulse groups, one endpoint at a time
   task act_grp(input logic [7:0] base, input int k);
      ucd_act_s e;
      begin
         for (int i = 0; i < 16; i++) begin
            // Codes 60 and 71 are never issued by the processor
            if (!((k == 2 && i == 0) || (k == 3 && i == 1))) begin
               e = '0;
               case (k)
                  0: e.stall[i] = 1'b1;
                  1: e.unstall[i] = 1'b1;
                  2: e.validate[i] = 1'b1;
                  default: e.clear[i] = 1'b1;
               endcase
               cmd(base + 8'(i));
               chk(act, e, "action");
            end
         end
         $display("test actions done");
      end
   endtask : act_grp
   // Byte reads per endpoint; only status read clears
   task rd_grp(input logic [7:0] base, input int k);
      logic [15:0] r;
      begin
         for (int i = 0; i < 16; i++) begin
            cmd(base + 8'(i));
            rd(r);
            chk(r, {8'h00, (k == 2 ? 8'ha0 : 8'h50) + 8'(i)}, "endpoint byte");
            chk(act.stat_clr, k == 0 ? 16'(1 << i) : 16'h0000, "status clear");
         end
         $display("test endpoint reads done");
      end
   endtask : rd_grp
   // Frame, identity and cause reads
   task t_misc;
      logic [15:0] r;
      begin
         cmd(8'hb4);
         rd(r);
         chk(r, 16'h07c1, "frame");
         cmd(8'hb5);
         rd(r);
         chk(r, 16'h3c3c, "identity");
         cmd(8'hc0);
         rd(r);
         chk(r, 16'h1248, "cause low");
         rd(r);
         chk(r, 16'h8421, "cause high");
         $display("test reads done");
      end
   endtask : t_misc
   // Fill an IN buffer one word past its limit
   task t_bufwr(input logic [3:0] ep, input logic iso);
      int lim;
      begin
         lim = iso ? ((1023 + 1) / 2) + 1 : ((64 + 1) / 2) + 1;
         cmd(8'h20 + 8'(ep));
         wd({8'h00, iso ? 8'hd0 : 8'hc0});
         cmd(8'(ep));
         for (int w = 0; w <= lim; w++) begin
            wd(16'(w) ^ 16'h5a00);
            chk(buf_wr, w < lim, "word accepted");
            if (w < lim) begin
               chk({buf_ep, buf_wdata}, {ep, 16'(w) ^ 16'h5a00}, "word");
            end
         end
         $display("test buffer write done");
      end
   endtask : t_bufwr
   // Drain three words of an OUT buffer
   task t_bufrd(input logic [3:0] ep);
      logic [15:0] r;
      begin
         cmd(8'h20 + 8'(ep));
         wd(16'h0080);
         cmd(8'h10 + 8'(ep));
         for (int w = 0; w < 3; w++) begin
            rd(r);
            chk(r, {8'hc5, npop}, "buffer word");
            chk({buf_pop, buf_ep}, {1'b1, ep}, "pop");
            npop++;
         end
         $display("test buffer read done");
      end
   endtask : t_bufrd
   // Locked writes dropped until unlock
   task t_lock;
      begin
         @(negedge clk_i);
         lock = 1'b1;
         @(negedge clk_i);
         lock = 1'b0;
         cmd(8'hb6);
         wd(16'h0011);
         chk(addr, 8'h5a, "locked");
         cmd(8'hb0);
         wd(16'h0000);
         cmd(8'hb6);
         wd(16'h0011);
         chk(addr, 8'h11, "unlocked");
         $display("test unlock done");
      end
   endtask : t_lock
   // Unassigned codes, set-up acknowledge, device reset
   task t_tail;
      logic [15:0] r;
      ucd_act_s e;
      begin
         cmd(8'h90);
         wd(16'h00ff);
         chk({addr, act, buf_wr}, {8'h11, 81'h0, 1'b0}, "unassigned");
         cmd(8'he8);
         rd(r);
         chk(r, 16'h0000, "unassigned read");
         e = '0;
         e.setup_ack = 1'b1;
         cmd(8'hf4);
         chk(act, e, "set-up");
         cmd(8'hf6);
         chk_idle();
         $display("test tail done");
      end
   endtask : t_tail
   // Main sequence
   initial begin
      repeat (8) @(negedge clk_i);
      nrst_i = 1'b1;
      chk_idle();
      t_cfg();
      t_regs();
      act_grp(8'h40, 0);
      act_grp(8'h80, 1);
      act_grp(8'h60, 2);
      act_grp(8'h70, 3);
      rd_grp(8'h50, 0);
      rd_grp(8'hd0, 1);
      rd_grp(8'ha0, 2);
      t_misc();
      t_bufwr(4'h2, 1'b0);
      t_bufwr(4'h5, 1'b1);
      t_bufrd(4'h0);
      t_bufrd(4'h3);
      t_lock();
      t_tail();
      test_done();
   end
endmodule : tb_usb_device_command_decoder
`default_nettype wire

// ==== tb/ucd_engine_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ucd_engine_model (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic buf_pop_i,
   output ucd_pkg::ucd_dev_s dev_o,
   output logic [15:0] buf_rdata_o
);
   import ucd_pkg::*;
   logic [7:0] cnt_r; // Words consumed so far
   // Fixed status and fault patterns, one per endpoint
   always_comb begin
      for (int i = 0; i < 16; i++) begin
         dev_o.status[i] = 8'h50 + 8'(i);
         dev_o.fault[i] = 8'ha0 + 8'(i);
      end
      dev_o.frame = 16'h07c1;
      dev_o.cause = 32'h8421_1248;
   end
   // Head word moves on every pop, so stale words do not repeat within 256 pops
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cnt_r <= 8'h00;
      end else if (buf_pop_i) begin
         cnt_r <= cnt_r + 8'h01;
      end
   end
   assign buf_rdata_o = {8'hc5, cnt_r};
endmodule : ucd_engine_model
`default_nettype wire
